/* File: hw/rx_partition_regs.vh */
// Register indexes, field layout, codes and reset values of the receive bank configuration.
`ifndef RX_PARTITION_REGS_VH
`define RX_PARTITION_REGS_VH

// Register indexes; the byte address on the bus is four times the index.
`define PART_COUNT_FIRST_IDX 20'h30906
`define AGG_MODE_FIRST_IDX 20'h30907
`define PART_COUNT_SECOND_IDX 20'h30a06
`define AGG_MODE_SECOND_IDX 20'h30a07

// Byte offset of each register word on the bus.
`define PART_COUNT_FIRST_ADR 22'h0c2418
`define AGG_MODE_FIRST_ADR 22'h0c241c
`define PART_COUNT_SECOND_ADR 22'h0c2818
`define AGG_MODE_SECOND_ADR 22'h0c281c

// Each bank owns a 2-bit field; bank n sits at bits 2n+1:2n.
`define BANK_FIELD_WIDTH 2
`define BANK_COUNT 4
`define REG_WIDTH 8

// Aggregation codes.
`define AGG_32BIT 2'h0
`define AGG_64BIT 2'h1
`define AGG_128BIT 2'h2
`define AGG_UNDEFINED 2'h3

// Partition count codes.
`define PART_ONE 2'h0
`define PART_TWO 2'h1
`define PART_FOUR 2'h2
`define PART_EIGHT 2'h3

// Width one-hot layout per bank: bit 0 is 32, bit 1 is 64, bit 2 is 128.
`define WIDTH_SEL_32 3'h1
`define WIDTH_SEL_64 3'h2
`define WIDTH_SEL_128 3'h4

// Partition address masks for 1, 2, 4 and 8 partitions.
`define MASK_ONE 3'h0
`define MASK_TWO 3'h1
`define MASK_FOUR 3'h3
`define MASK_EIGHT 3'h7

// Reset value of every configuration register.
`define CONFIG_RESET 8'h00

`endif

/* File: hw/rx_buffer_partition_config.v */
// Wishbone configuration registers for the receive bank width and partition count of two cores.
// Function
// - Bank 0 aggregation mode comes from bits 1:0 of the aggregation register.
// - Banks 1, 2, 3 aggregation modes come from bits 3:2, 5:4, 7:6.
// - Aggregation code 00 runs the bank with 32-bit read width.
// - Aggregation code 01 runs the bank with 64-bit read width.
// - Aggregation code 10 runs the bank with 128-bit read width.
// - Partition register uses the same per-bank fields, bank 3 in bits 7:6.
// - Partition codes 00, 01, 10, 11 give 1, 2, 4, 8 equal partitions.
// - Each of the two interface cores has its own register pair.
`timescale 1ns/1ps
`include "rx_partition_regs.vh"

module rx_buffer_partition_config
(
    input wire clk, // System bus clock, 100 MHz.
    input wire rstn, // Asynchronous reset, active low.
    input wire wb_cyc_i, // Wishbone cycle.
    input wire wb_stb_i, // Wishbone strobe.
    input wire wb_we_i, // Wishbone write enable.
    input wire [21:0] wb_adr_i, // Wishbone byte address.
    input wire [3:0] wb_sel_i, // Wishbone byte selects.
    input wire [31:0] wb_dat_i, // Wishbone write data.
    output reg [31:0] wb_dat_o, // Wishbone read data.
    output reg wb_ack_o, // Wishbone acknowledge.
    output reg [7:0] first_core_agg_mode, // Aggregation register, first core.
    output reg [7:0] first_core_part_count, // Partition register, first core.
    output reg [7:0] second_core_agg_mode, // Aggregation register, second core.
    output reg [7:0] second_core_part_count, // Partition register, second core.
    output reg [11:0] first_core_width_sel, // Per-bank one-hot read width, first core.
    output reg [11:0] first_core_part_mask, // Per-bank partition address mask, first core.
    output reg [3:0] first_core_agg_invalid, // Per-bank undefined width code, first core.
    output reg [11:0] second_core_width_sel, // Per-bank one-hot read width, second core.
    output reg [11:0] second_core_part_mask, // Per-bank partition address mask, second core.
    output reg [3:0] second_core_agg_invalid // Per-bank undefined width code, second core.
);

    // Turns an aggregation code into a one-hot read width; code 11 selects no width.
    function [2:0] width_of;
        input [1:0] code;
        begin
            case (code)
                `AGG_32BIT: width_of = `WIDTH_SEL_32;
                `AGG_64BIT: width_of = `WIDTH_SEL_64;
                `AGG_128BIT: width_of = `WIDTH_SEL_128;
                default: width_of = 3'h0;
            endcase
        end
    endfunction

    // Turns a partition code into the mask applied to the 3-bit FIFO read address.
    function [2:0] mask_of;
        input [1:0] code;
        begin
            case (code)
                `PART_ONE: mask_of = `MASK_ONE;
                `PART_TWO: mask_of = `MASK_TWO;
                `PART_FOUR: mask_of = `MASK_FOUR;
                default: mask_of = `MASK_EIGHT;
            endcase
        end
    endfunction

    wire request = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire write_lane0 = request & wb_we_i & wb_sel_i[0];
    reg [31:0] next_rdata;

    // Read mux; unmapped addresses read as zero, upper bits always zero.
    always @*
    begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            `PART_COUNT_FIRST_ADR: next_rdata[7:0] = first_core_part_count;
            `AGG_MODE_FIRST_ADR: next_rdata[7:0] = first_core_agg_mode;
            `PART_COUNT_SECOND_ADR: next_rdata[7:0] = second_core_part_count;
            `AGG_MODE_SECOND_ADR: next_rdata[7:0] = second_core_agg_mode;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Bus answer: one ack a cycle after the request, dropped the next cycle so
    // a held strobe cannot be taken twice. Writes land in the same edge the ack rises.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            first_core_agg_mode <= `CONFIG_RESET;
            first_core_part_count <= `CONFIG_RESET;
            second_core_agg_mode <= `CONFIG_RESET;
            second_core_part_count <= `CONFIG_RESET;
        end
        else
        begin
            wb_ack_o <= request;
            wb_dat_o <= request ? next_rdata : 32'h0000_0000;
            if (write_lane0 && wb_adr_i == `PART_COUNT_FIRST_ADR)
                first_core_part_count <= wb_dat_i[7:0];
            if (write_lane0 && wb_adr_i == `AGG_MODE_FIRST_ADR)
                first_core_agg_mode <= wb_dat_i[7:0];
            if (write_lane0 && wb_adr_i == `PART_COUNT_SECOND_ADR)
                second_core_part_count <= wb_dat_i[7:0];
            if (write_lane0 && wb_adr_i == `AGG_MODE_SECOND_ADR)
                second_core_agg_mode <= wb_dat_i[7:0];
        end
    end

    // Per-bank decode, registered so the bank controls see glitch-free levels.
    // The decoded outputs trail a register write by one clock.
    genvar b;
    generate
        for (b = 0; b < `BANK_COUNT; b = b + 1)
        begin : bank
            always @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    first_core_width_sel[3*b+2:3*b] <= `WIDTH_SEL_32;
                    first_core_part_mask[3*b+2:3*b] <= `MASK_ONE;
                    first_core_agg_invalid[b] <= 1'b0;
                    second_core_width_sel[3*b+2:3*b] <= `WIDTH_SEL_32;
                    second_core_part_mask[3*b+2:3*b] <= `MASK_ONE;
                    second_core_agg_invalid[b] <= 1'b0;
                end
                else
                begin
                    first_core_width_sel[3*b+2:3*b] <=
                        width_of(first_core_agg_mode[2*b+1:2*b]);
                    first_core_part_mask[3*b+2:3*b] <=
                        mask_of(first_core_part_count[2*b+1:2*b]);
                    first_core_agg_invalid[b] <=
                        first_core_agg_mode[2*b+1:2*b] == `AGG_UNDEFINED;
                    second_core_width_sel[3*b+2:3*b] <=
                        width_of(second_core_agg_mode[2*b+1:2*b]);
                    second_core_part_mask[3*b+2:3*b] <=
                        mask_of(second_core_part_count[2*b+1:2*b]);
                    second_core_agg_invalid[b] <=
                        second_core_agg_mode[2*b+1:2*b] == `AGG_UNDEFINED;
                end
            end
        end
    endgenerate

endmodule

/* File: sim/rx_buffer_partition_config_checker.sv */
// Concurrent checks on the bus and decoded outputs of the receive bank configuration.
`timescale 1ns/1ps
`include "rx_partition_regs.vh"
module cfg_checker
(
    input wire clk, // Bus clock.
    input wire rstn, // Reset, active low.
    input wire wb_cyc_i, // Cycle.
    input wire wb_stb_i, // Strobe.
    input wire wb_we_i, // Write enable.
    input wire [21:0] wb_adr_i, // Address.
    input wire [3:0] wb_sel_i, // Byte selects.
    input wire [31:0] wb_dat_i, // Write data.
    input wire [31:0] wb_dat_o, // Read data.
    input wire wb_ack_o, // Acknowledge.
    input wire [7:0] first_core_agg_mode, // Aggregation register.
    input wire [7:0] first_core_part_count, // Partition register.
    input wire [7:0] second_core_agg_mode, // Second aggregation register.
    input wire [11:0] first_core_width_sel, // Decoded widths.
    input wire [11:0] first_core_part_mask, // Decoded masks.
    input wire [3:0] first_core_agg_invalid, // Undefined code flags.
    input wire [11:0] second_core_width_sel // Decoded widths, second core.
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // A taken write is a request that is not already being answered.
    wire wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
    ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a one-cycle answer");
    agg_store_a: assert property (wr && wb_adr_i == `AGG_MODE_FIRST_ADR
        |=> first_core_agg_mode == $past(wb_dat_i[7:0])) else $error("write not stored");
    other_core_a: assert property (!(wr && wb_adr_i == `AGG_MODE_SECOND_ADR)
        |=> $stable(second_core_agg_mode)) else $error("second core changed");
    width_32_a: assert property (first_core_agg_mode[1:0] == 2'h0
        |=> first_core_width_sel[2:0] == 3'h1) else $error("bank 0 width");
    width_64_a: assert property (first_core_agg_mode[3:2] == 2'h1
        |=> first_core_width_sel[5:3] == 3'h2) else $error("bank 1 width");
    width_128_a: assert property (first_core_agg_mode[7:6] == 2'h2
        |=> first_core_width_sel[11:9] == 3'h4) else $error("bank 3 width");
    part_eight_a: assert property (first_core_part_count[7:6] == 2'h3
        |=> first_core_part_mask[11:9] == 3'h7) else $error("bank 3 mask");
    agg_invalid_a: assert property (first_core_agg_mode[5:4] == 2'h3
        |=> first_core_agg_invalid[2]) else $error("bank 2 flag");
    second_width_a: assert property (second_core_agg_mode[1:0] == 2'h1
        |=> second_core_width_sel[2:0] == 3'h2) else $error("second core bank 0 width");
    c_write: cover property (wr && wb_adr_i == `AGG_MODE_FIRST_ADR);
    c_eight: cover property (first_core_part_count == 8'hff);
    c_bad: cover property (first_core_agg_invalid != 4'h0);
endmodule
bind rx_buffer_partition_config cfg_checker chk (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .first_core_agg_mode(first_core_agg_mode), .first_core_part_count(first_core_part_count),
    .second_core_agg_mode(second_core_agg_mode), .first_core_width_sel(first_core_width_sel),
    .first_core_part_mask(first_core_part_mask), .first_core_agg_invalid(first_core_agg_invalid),
    .second_core_width_sel(second_core_width_sel));

/* File: sim/rx_buffer_partition_config_tb.sv */
// Self-checking bench for the receive bank configuration registers.
`timescale 1ns/1ps
`include "rx_partition_regs.vh"
module rx_buffer_partition_config_tb;
    logic clk, rstn, cyc, stb, we;
    logic [21:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, dat_o, e, seed;
    logic ack;
    logic [7:0] m [4];
    logic [21:0] ad [4];
    logic [31:0] q [$];
    logic [7:0] vals [6];
    int miscompares, checks_done, n;
    rx_buffer_partition_config uut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .first_core_agg_mode(), .first_core_part_count(),
        .second_core_agg_mode(), .second_core_part_count(), .first_core_width_sel(),
        .first_core_part_mask(), .first_core_agg_invalid(), .second_core_width_sel(),
        .second_core_part_mask(), .second_core_agg_invalid());
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // One classic cycle; on a read d is the expected byte, noted for the monitor.
    task automatic wb(input logic w, input logic [21:0] a, input logic [7:0] d, input logic [3:0] s);
        if (!w)
            q.push_back({24'h0, d});
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= {xs() & 32'hffffff00} | d;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            miscompares++;
            summarize();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    // Read data is judged at the edge where the answer is sampled.
    always @(posedge clk)
        if (ack === 1'b1 && we === 1'b0)
        begin
            e = q.pop_front();
            checks_done++;
            if (dat_o !== e)
            begin
                $display("unexpected at %0t got %h exp %h", $time, dat_o, e);
                miscompares++;
            end
        end
    initial
    begin
        {cyc, stb, we, adr, sel, dat, rstn} = 0;
        seed = 32'd84969;
        ad = '{`PART_COUNT_FIRST_ADR, `AGG_MODE_FIRST_ADR, `PART_COUNT_SECOND_ADR,
            `AGG_MODE_SECOND_ADR};
        vals = '{8'h00, 8'h55, 8'haa, 8'hff, 8'he4, 8'h1b};
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            wb(0, ad[i], 8'h00, 4'hf);
            m[i] = 8'h00;
        end
        $display("reset test done");
        // Every code in every bank field, then distinct codes per bank.
        for (int c = 0; c < 6; c++)
            for (int i = 0; i < 4; i++)
            begin
                wb(1, ad[i], vals[c], 4'hf);
                wb(0, ad[i], vals[c], 4'hf);
                m[i] = vals[c];
            end
        $display("code test done");
        // Unselected byte and unmapped address leave everything alone.
        wb(1, ad[0], 8'h5a, 4'he);
        wb(0, ad[0], m[0], 4'hf);
        wb(1, 22'h0c2420, 8'h77, 4'hf);
        wb(0, 22'h0c2420, 8'h00, 4'hf);
        $display("refusal test done");
        for (int k = 0; k < 40; k++)
        begin
            e = xs();
            if (e[2])
                m[e[1:0]] = e[15:8];
            wb(e[2], ad[e[1:0]], e[2] ? e[15:8] : m[e[1:0]], 4'hf);
        end
        $display("random test done");
        summarize();
    end
endmodule
